// ### design/dvi_pkg.sv
// Constants and register map of the delta angle and delta velocity integrator
package dvi_pkg;
   // Register byte addresses
   localparam logic [6:0] ADDR_ANGLE_STEP_X_LOW_WORD = 7'h24;
   localparam logic [6:0] ADDR_ANGLE_STEP_X_HIGH_WORD = 7'h26;
   localparam logic [6:0] ADDR_ANGLE_STEP_Y_LOW_WORD = 7'h28;
   localparam logic [6:0] ADDR_ANGLE_STEP_Y_HIGH_WORD = 7'h2a;
   localparam logic [6:0] ADDR_ANGLE_STEP_Z_LOW_WORD = 7'h2c;
   localparam logic [6:0] ADDR_ANGLE_STEP_Z_HIGH_WORD = 7'h2e;
   localparam logic [6:0] ADDR_VELOCITY_STEP_X_LOW_WORD = 7'h30;
   localparam logic [6:0] ADDR_VELOCITY_STEP_X_HIGH_WORD = 7'h32;
   localparam logic [15:0] READ_UNMAPPED = 16'h0000;
   localparam logic [31:0] RESULT_RESET = 32'h00000000;

   // Widths
   localparam int SAMPLE_W = 16;
   localparam int ACC_W = 29;
   localparam int GAIN_W = 21;
   localparam int GAIN_FRAC = 16;
   localparam int DEC_W = 11;
   localparam int AXES = 6;

   // Nominal internal sample rate in SPS
   localparam longint SAMPLE_RATE_SPS = 2000;
   // Gyro rate full scale per model, deg/s
   localparam longint RATE_FS_M1 = 125;
   localparam longint RATE_FS_M2 = 500;
   localparam longint RATE_FS_M3 = 2000;
   // Delta angle full scale per model, deg
   localparam longint ANGLE_MAX_M1 = 360;
   localparam longint ANGLE_MAX_M2 = 720;
   localparam longint ANGLE_MAX_M3 = 2160;
   // Accel full scale in mm/s^2 (8 g) and delta velocity full scale in mm/s
   localparam longint ACCEL_FS_MMS2 = 78453;
   localparam longint VEL_MAX_MMS = 100000;

   // Code32 = pair_sum * gain / 2^16 with gain = fs_in * 2^32 / (2 * fs * max)
   localparam longint GAIN_SCALE = 64'h0000000100000000;
   localparam logic [GAIN_W-1:0] GAIN_ANGLE_M1 =
      GAIN_W'((RATE_FS_M1 * GAIN_SCALE) / (2 * SAMPLE_RATE_SPS * ANGLE_MAX_M1));
   localparam logic [GAIN_W-1:0] GAIN_ANGLE_M2 =
      GAIN_W'((RATE_FS_M2 * GAIN_SCALE) / (2 * SAMPLE_RATE_SPS * ANGLE_MAX_M2));
   localparam logic [GAIN_W-1:0] GAIN_ANGLE_M3 =
      GAIN_W'((RATE_FS_M3 * GAIN_SCALE) / (2 * SAMPLE_RATE_SPS * ANGLE_MAX_M3));
   localparam logic [GAIN_W-1:0] GAIN_VEL =
      GAIN_W'((ACCEL_FS_MMS2 * GAIN_SCALE) / (2 * SAMPLE_RATE_SPS * VEL_MAX_MMS));

   typedef enum logic [1:0] {
      DVI_MODEL_1,
      DVI_MODEL_2,
      DVI_MODEL_3,
      DVI_MODEL_RSVD
   } dvi_model_t;
endpackage

// ### design/dvi_axis_integ.sv
// One axis trapezoidal integrator with scaling and saturation
`timescale 1ns/1ns
module dvi_axis_integ
   import dvi_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sample_valid,
   input wire logic period_last,
   input wire logic signed [SAMPLE_W-1:0] sample,
   input wire logic [GAIN_W-1:0] gain,
   output logic signed [31:0] result,
   output logic result_load
);
   localparam int PROD_W = ACC_W + GAIN_W + 1;
   localparam logic signed [PROD_W-1:0] POS_LIM = PROD_W'(64'sh000000007fffffff);
   localparam logic signed [PROD_W-1:0] NEG_LIM = PROD_W'(-64'sh0000000080000000);

   logic signed [SAMPLE_W-1:0] prev;
   logic signed [ACC_W-1:0] acc;
   wire logic signed [ACC_W-1:0] pair = ACC_W'(sample) + ACC_W'(prev);
   wire logic signed [ACC_W-1:0] total = acc + pair;
   wire logic signed [PROD_W-1:0] prod =
      PROD_W'(total) * $signed({1'b0, gain});
   wire logic signed [PROD_W-1:0] scaled = prod >>> GAIN_FRAC;
   wire logic signed [31:0] next_result =
      (scaled > POS_LIM) ? 32'sh7fffffff :
      (scaled < NEG_LIM) ? 32'sh80000000 : scaled[31:0];

   // Each sample is summed with its predecessor, the previous period's last included
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev <= '0;
         acc <= '0;
         result <= RESULT_RESET;
         result_load <= 1'b0;
      end else begin
         result_load <= sample_valid && period_last;
         if (sample_valid) begin
            prev <= sample;
            acc <= period_last ? '0 : total;
            if (period_last) begin
               result <= next_result;
            end
         end
      end
   end
endmodule // dvi_axis_integ

// ### design/dvi_integrator.sv
// Delta angle and delta velocity integrator with its read-only output words
//
// Behaviour
// - X angle high word: 16-bit two's complement, LSB is max angle over 2^15.
// - X angle low word holds bits 15:0 of the 32-bit result.
// - Y angle uses the same high/low format at its own addresses.
// - Z angle uses the same high/low format at its own addresses.
// - High word spans 0x7fff down to 0x8000; 0xffff is minus one LSB.
// - Full word spans 0x7fffffff down to 0x80000000; LSB is max over 2^31.
// - Velocity: sum of D sample pairs over 2fs, D is decimation plus one.
// - Scaling uses the nominal 2000 SPS internal rate.
// - X velocity is two words forming one 32-bit value; Y and Z are 32-bit output ports.
// - X velocity high word: 16-bit, 100 m/s range, LSB 100 over 2^15.
// - X velocity low word carries the extra low resolution bits.
// - Angle words are read-only, undefined default, not stored in flash.
// - Velocity words are read-only, undefined default, not stored in flash.
// - Angle uses the same trapezoidal sum over D gyro samples.
// - Max delta angle follows gyro model: 360, 720 or 2160 degrees.
`timescale 1ns/1ns
module dvi_integrator
   import dvi_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic SAMPLE_VALID,
   input wire logic signed [SAMPLE_W-1:0] GYRO_X,
   input wire logic signed [SAMPLE_W-1:0] GYRO_Y,
   input wire logic signed [SAMPLE_W-1:0] GYRO_Z,
   input wire logic signed [SAMPLE_W-1:0] ACCEL_X,
   input wire logic signed [SAMPLE_W-1:0] ACCEL_Y,
   input wire logic signed [SAMPLE_W-1:0] ACCEL_Z,
   input wire logic [DEC_W-1:0] DECIMATION_SETTING,
   input wire logic [1:0] GYRO_MODEL,
   input wire logic REG_RD,
   input wire logic [6:0] REG_ADDR,
   output logic [15:0] REG_RDATA,
   output logic REG_RVALID,
   output logic UPDATE_INDICATOR_PIN,
   output logic [31:0] VELOCITY_STEP_Y,
   output logic [31:0] VELOCITY_STEP_Z
);
   logic [DEC_W-1:0] dec_count;
   logic [GAIN_W-1:0] gain_angle;
   logic [31:0] angle_x;
   logic [31:0] angle_y;
   logic [31:0] angle_z;
   logic [31:0] vel_x;
   logic signed [SAMPLE_W-1:0] samples [AXES];
   logic [GAIN_W-1:0] gains [AXES];
   logic signed [31:0] results [AXES];
   logic [AXES-1:0] loads;

   // Gain for the fitted gyro model
   function automatic logic [GAIN_W-1:0] model_gain(input logic [1:0] model);
      case (dvi_model_t'(model))
         DVI_MODEL_1: model_gain = GAIN_ANGLE_M1;
         DVI_MODEL_2: model_gain = GAIN_ANGLE_M2;
         DVI_MODEL_3: model_gain = GAIN_ANGLE_M3;
         default: model_gain = GAIN_ANGLE_M3;
      endcase
   endfunction

   // Decimation period: D = setting + 1 samples, last one closes the period
   wire logic period_last = (dec_count >= DECIMATION_SETTING);
   wire logic [DEC_W-1:0] next_dec_count = period_last ? '0 : dec_count + 1'b1;

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         dec_count <= '0;
      end else if (SAMPLE_VALID) begin
         dec_count <= next_dec_count;
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         gain_angle <= GAIN_ANGLE_M1;
      end else begin
         gain_angle <= model_gain(GYRO_MODEL);
      end
   end

   assign samples[0] = GYRO_X;
   assign samples[1] = GYRO_Y;
   assign samples[2] = GYRO_Z;
   assign samples[3] = ACCEL_X;
   assign samples[4] = ACCEL_Y;
   assign samples[5] = ACCEL_Z;
   assign gains[0] = gain_angle;
   assign gains[1] = gain_angle;
   assign gains[2] = gain_angle;
   assign gains[3] = GAIN_VEL;
   assign gains[4] = GAIN_VEL;
   assign gains[5] = GAIN_VEL;

   genvar g;
   generate
      for (g = 0; g < AXES; g++) begin : g_axis
         dvi_axis_integ u_integ (
            .clk(REF_CLK),
            .rst(SYS_RST),
            .sample_valid(SAMPLE_VALID),
            .period_last(period_last),
            .sample(samples[g]),
            .gain(gains[g]),
            .result(results[g]),
            .result_load(loads[g])
         );
      end
   endgenerate

   // Every axis loads both words on the same edge, so a read pair is coherent only if no update lands between its two reads
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         angle_x <= RESULT_RESET;
         angle_y <= RESULT_RESET;
         angle_z <= RESULT_RESET;
         vel_x <= RESULT_RESET;
         VELOCITY_STEP_Y <= RESULT_RESET;
         VELOCITY_STEP_Z <= RESULT_RESET;
         UPDATE_INDICATOR_PIN <= 1'b0;
      end else begin
         UPDATE_INDICATOR_PIN <= loads[0];
         if (loads[0]) begin
            angle_x <= results[0];
            angle_y <= results[1];
            angle_z <= results[2];
            vel_x <= results[3];
            VELOCITY_STEP_Y <= results[4];
            VELOCITY_STEP_Z <= results[5];
         end
      end
   end

   // Read-only map; the byte address of either byte of a word selects that word
   wire logic [6:0] word_addr = {REG_ADDR[6:1], 1'b0};
   wire logic [15:0] read_mux =
      (word_addr == ADDR_ANGLE_STEP_X_LOW_WORD) ? angle_x[15:0] :
      (word_addr == ADDR_ANGLE_STEP_X_HIGH_WORD) ? angle_x[31:16] :
      (word_addr == ADDR_ANGLE_STEP_Y_LOW_WORD) ? angle_y[15:0] :
      (word_addr == ADDR_ANGLE_STEP_Y_HIGH_WORD) ? angle_y[31:16] :
      (word_addr == ADDR_ANGLE_STEP_Z_LOW_WORD) ? angle_z[15:0] :
      (word_addr == ADDR_ANGLE_STEP_Z_HIGH_WORD) ? angle_z[31:16] :
      (word_addr == ADDR_VELOCITY_STEP_X_LOW_WORD) ? vel_x[15:0] :
      (word_addr == ADDR_VELOCITY_STEP_X_HIGH_WORD) ? vel_x[31:16] :
      READ_UNMAPPED;

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         REG_RDATA <= READ_UNMAPPED;
         REG_RVALID <= 1'b0;
      end else begin
         REG_RVALID <= REG_RD;
         if (REG_RD) begin
            REG_RDATA <= read_mux;
         end
      end
   end
endmodule // dvi_integrator

// ### tb/dvi_integrator_monitor.sv
// Checker for the integrator's read port and update timing
`timescale 1ns/1ns
module dvi_integrator_monitor
   import dvi_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic SAMPLE_VALID,
   input wire logic [DEC_W-1:0] DECIMATION_SETTING,
   input wire logic REG_RD,
   input wire logic [6:0] REG_ADDR,
   input wire logic [15:0] REG_RDATA,
   input wire logic REG_RVALID,
   input wire logic UPDATE_INDICATOR_PIN,
   input wire logic [31:0] VELOCITY_STEP_Y,
   input wire logic [31:0] VELOCITY_STEP_Z
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   wire logic mapped = REG_ADDR[6:1] >= 6'h12 && REG_ADDR[6:1] <= 6'h19;
   rd_answered_a: assert property (REG_RD |=> REG_RVALID)
      else $error("read not answered");
   no_stray_answer_a: assert property (REG_RVALID |-> $past(REG_RD))
      else $error("answer without read");
   unmapped_zero_a: assert property (REG_RD && !mapped |=> REG_RDATA == 16'h0000)
      else $error("unmapped read not zero");
   rdata_holds_a: assert property (!REG_RD |=> $stable(REG_RDATA))
      else $error("read data moved");
   update_cause_a: assert property (UPDATE_INDICATOR_PIN |-> $past(SAMPLE_VALID, 2))
      else $error("update without sample");
   single_sample_a: assert property (SAMPLE_VALID && DECIMATION_SETTING == 0 |-> ##2 UPDATE_INDICATOR_PIN)
      else $error("no update at decimation zero");
   vel_y_load_a: assert property ($changed(VELOCITY_STEP_Y) |-> UPDATE_INDICATOR_PIN)
      else $error("y velocity moved between updates");
   vel_z_load_a: assert property ($changed(VELOCITY_STEP_Z) |-> UPDATE_INDICATOR_PIN)
      else $error("z velocity moved between updates");
   cover property (UPDATE_INDICATOR_PIN && DECIMATION_SETTING != 0);
   cover property (REG_RD && !mapped);
   cover property (REG_RVALID ##1 REG_RVALID);
endmodule // dvi_integrator_monitor
bind dvi_integrator dvi_integrator_monitor dvi_integrator_monitor_inst (.REF_CLK(REF_CLK),
   .SYS_RST(SYS_RST), .SAMPLE_VALID(SAMPLE_VALID), .DECIMATION_SETTING(DECIMATION_SETTING),
   .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
   .UPDATE_INDICATOR_PIN(UPDATE_INDICATOR_PIN), .VELOCITY_STEP_Y(VELOCITY_STEP_Y),
   .VELOCITY_STEP_Z(VELOCITY_STEP_Z));

// ### tb/dvi_host_model.sv
// Host reader that strobes register reads
`timescale 1ns/1ns
module dvi_host_model (
   input wire logic clk,
   output logic reg_rd,
   output logic [6:0] reg_addr
);
   initial begin
      reg_rd = 1'b0;
      reg_addr = 7'h00;
   end
   // Strobe stays high across back-to-back calls
   task automatic read(input logic [6:0] addr);
      @(posedge clk);
      #10;
      reg_rd = 1'b1;
      reg_addr = addr;
   endtask
   // Released address shows its inverse so stale values are not mistaken
   task automatic stop();
      @(posedge clk);
      #10;
      reg_rd = 1'b0;
      reg_addr = ~reg_addr;
   endtask
endmodule // dvi_host_model

// ### tb/test_dvi_integrator.sv
// Self-checking bench for the integrator
`timescale 1ns/1ns
module test_dvi_integrator;
   import dvi_pkg::*;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic sample_valid = 1'b0;
   logic signed [15:0] smp [6] = '{default: 16'h0000};
   logic [DEC_W-1:0] dec_set = '0;
   logic [1:0] model = 2'h0;
   logic reg_rd;
   logic [6:0] reg_addr;
   logic [15:0] reg_rdata;
   logic reg_rvalid;
   logic upd;
   logic [31:0] vel_y;
   logic [31:0] vel_z;
   logic [31:0] e [6] = '{default: RESULT_RESET};
   longint acc [6] = '{default: 0};
   longint prv [6] = '{default: 0};
   logic [15:0] q [$];
   int failures = 0;
   int compares = 0;
   int gap = 0;
   int last_gap = 0;
   always #50 ref_clk = ~ref_clk;
   // Cycles between update pulses, as a host would time the update rate
   always @(posedge ref_clk) begin
      if (upd === 1'b1) begin
         last_gap <= gap;
         gap <= 1;
      end else begin
         gap <= gap + 1;
      end
   end
   dvi_integrator dvi_integrator_inst (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
      .SAMPLE_VALID(sample_valid), .GYRO_X(smp[0]), .GYRO_Y(smp[1]), .GYRO_Z(smp[2]),
      .ACCEL_X(smp[3]), .ACCEL_Y(smp[4]), .ACCEL_Z(smp[5]), .DECIMATION_SETTING(dec_set),
      .GYRO_MODEL(model), .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_RDATA(reg_rdata),
      .REG_RVALID(reg_rvalid), .UPDATE_INDICATOR_PIN(upd), .VELOCITY_STEP_Y(vel_y),
      .VELOCITY_STEP_Z(vel_z));
   dvi_host_model dvi_host_model_inst (.clk(ref_clk), .reg_rd(reg_rd), .reg_addr(reg_addr));
   function automatic logic [31:0] scale(longint a, longint g);
      longint p;
      p = (a * g) >>> 16;
      if (p > 64'sh7fffffff) p = 64'sh7fffffff;
      if (p < -64'sh80000000) p = -64'sh80000000;
      return p[31:0];
   endfunction
   function automatic longint gain(int i);
      if (i > 2) return GAIN_VEL;
      case (model)
         2'h0: return GAIN_ANGLE_M1;
         2'h1: return GAIN_ANGLE_M2;
         default: return GAIN_ANGLE_M3;
      endcase
   endfunction
   task automatic results();
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(logic [31:0] exp, logic [31:0] act);
      compares++;
      if (act !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, act);
      end
   endtask
   task automatic rd(logic [6:0] a, logic [15:0] x);
      q.push_back(x);
      dvi_host_model_inst.read(a);
   endtask
   always @(negedge ref_clk) begin
      if (reg_rvalid === 1'b1) chk({16'h0000, q.pop_front()}, {16'h0000, reg_rdata});
   end
   task automatic read_all();
      for (int k = 0; k < 8; k++) begin
         rd(7'h24 + 7'(2 * k), k[0] ? e[k / 2][31:16] : e[k / 2][15:0]);
      end
      rd(7'h35, 16'h0000);
      rd(7'h27, e[0][31:16]);
      dvi_host_model_inst.stop();
      chk(e[4], vel_y);
      chk(e[5], vel_z);
   endtask
   task automatic period(int p);
      model = 2'(p);
      dec_set = DEC_W'($urandom_range(3, 0));
      for (int d = 0; d <= dec_set; d++) begin
         @(posedge ref_clk);
         #10;
         sample_valid = 1'b1;
         for (int i = 0; i < 6; i++) begin
            smp[i] = p > 9 ? {p[0], {15{~p[0]}}} : 16'($urandom);
            acc[i] += smp[i] + prv[i];
            prv[i] = smp[i];
         end
      end
      for (int i = 0; i < 6; i++) begin
         e[i] = scale(acc[i], gain(i));
         acc[i] = 0;
      end
      @(posedge ref_clk);
      #10;
      sample_valid = 1'b0;
      for (int i = 0; i < 8; i++) begin
         @(negedge ref_clk);
         if (upd === 1'b1) break;
         if (i == 7) begin
            failures++;
            results();
         end
      end
      read_all();
   endtask
   initial begin
      void'($urandom(32'h94a89859));
      repeat (10) @(posedge ref_clk);
      #10;
      sys_rst = 1'b0;
      read_all();
      for (int p = 0; p < 12; p++) period(p);
      // At decimation zero the update rate equals the sample rate
      dec_set = '0;
      for (int s = 0; s < 2; s++) begin
         @(posedge ref_clk);
         #10;
         sample_valid = 1'b1;
         @(posedge ref_clk);
         #10;
         sample_valid = 1'b0;
         repeat (2) @(posedge ref_clk);
      end
      repeat (4) @(posedge ref_clk);
      chk(32'h00000000, 32'(q.size()));
      chk(32'h00000004, 32'(last_gap));
      results();
   end
endmodule // test_dvi_integrator
